// ===== src/eep_ctrl.sv
`timescale 1ns/1ps
`include "eep_regs.svh"
// ==========================================
// Write-data FIFO
module eep_fifo #(
  parameter int W = `EEP_FIFO_W,
  parameter int D = `EEP_FIFO_D
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0]         mem [D];
  logic [$clog2(D)-1:0] wp_r;
  logic [$clog2(D)-1:0] rp_r;
  logic [$clog2(D):0]   cnt_r;
  logic                 push;
  logic                 pop;
  assign in_ready  = cnt_r != D[$clog2(D):0];
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_r + {{($clog2(D)-1){1'b0}}, push};
      rp_r  <= rp_r + {{($clog2(D)-1){1'b0}}, pop};
      cnt_r <= cnt_r + {{$clog2(D){1'b0}}, push} - {{$clog2(D){1'b0}}, pop};
    end
  end
endmodule

// ==========================================
// Bus controller end
module eep_ctrl
  import eep_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_op,
  input  wire logic [2:0]  cmd_dev,
  input  wire logic [14:0] cmd_addr,
  input  wire logic [6:0]  cmd_len,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [7:0]  wr_data,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  output logic             done,
  output logic             nack,
  eep_if.ctrl              bus
);
  function automatic logic [1:0] pat(eep_sym_e k, logic [1:0] q, logic v);
    logic hi;
    hi = q == 2'h1 || q == 2'h2;
    unique case (k)
      SYM_START: pat = {hi, !q[1]};
      SYM_STOP:  pat = {q != 2'h0, q[1]};
      default:   pat = {hi, v};
    endcase
  endfunction

  eep_cst_e    st_r;
  eep_op_e     op_r;
  eep_sym_e    kind_r;
  eep_sym_e    go_kind;
  logic [2:0]  dev_r;
  logic [14:0] addr_r;
  logic [6:0]  cnt_r;
  logic        lau_r;
  logic        run_r;
  logic [3:0]  div_r;
  logic [1:0]  q_r;
  logic [3:0]  bitn_r;
  logic [8:0]  txw_r;
  logic [8:0]  rxw_r;
  logic [8:0]  go_tx;
  logic        scl_r;
  logic        sda_r;
  logic        s1_r;
  logic        s2_r;
  logic        tick;
  logic        sym_end;
  logic        sym_done;
  logic        go;
  logic        f_valid;
  logic [7:0]  f_data;
  logic        last;

  eep_fifo #(.W(`EEP_FIFO_W), .D(`EEP_FIFO_D)) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (go && st_r == C_WDAT),
    .out_data  (f_data)
  );

  assign last     = cnt_r <= 7'h01;
  assign tick     = run_r && div_r == `EEP_QTR_LAST;
  assign sym_end  = tick && q_r == 2'h3;
  assign sym_done = sym_end && !(kind_r == SYM_BIT && bitn_r != `EEP_LAST_BIT);
  // An empty FIFO stalls with SCL held low
  assign go = st_r != C_IDLE && !run_r && !lau_r && (st_r != C_WDAT || f_valid);
  assign cmd_ready = st_r == C_IDLE;

  always_comb
  begin
    go_kind = SYM_BIT;
    unique case (st_r)
      C_START, C_RSTA: go_kind = SYM_START;
      C_STOP:          go_kind = SYM_STOP;
      default:         go_kind = SYM_BIT;
    endcase
    unique case (st_r)
      C_DEV:   go_tx = {`EEP_PREAMBLE, dev_r, 1'b0, 1'b1};
      C_RDEV:  go_tx = {`EEP_PREAMBLE, dev_r, 1'b1, 1'b1};
      C_AHI:   go_tx = {1'b0, addr_r[14:8], 1'b1};
      C_ALO:   go_tx = {addr_r[7:0], 1'b1};
      C_WDAT:  go_tx = {f_data, 1'b1};
      C_RDAT:  go_tx = {8'hFF, last};
      default: go_tx = 9'h1FF;
    endcase
  end

  // ==========================================
  // Symbol engine: four quarters per symbol
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      run_r  <= 1'b0;
      div_r  <= '0;
      q_r    <= '0;
      bitn_r <= '0;
      kind_r <= SYM_STOP;
      txw_r  <= 9'h1FF;
      scl_r  <= 1'b1;
      sda_r  <= 1'b1;
    end
    else if (go)
    begin
      run_r  <= 1'b1;
      div_r  <= '0;
      q_r    <= '0;
      bitn_r <= '0;
      kind_r <= go_kind;
      txw_r  <= go_tx;
      {scl_r, sda_r} <= pat(go_kind, 2'h0, go_tx[8]);
    end
    else if (sym_done)
      run_r <= 1'b0;
    else if (sym_end)
    begin
      div_r  <= '0;
      q_r    <= '0;
      bitn_r <= bitn_r + 4'h1;
      txw_r  <= {txw_r[7:0], 1'b1};
      {scl_r, sda_r} <= pat(kind_r, 2'h0, txw_r[7]);
    end
    else if (tick)
    begin
      div_r <= '0;
      q_r   <= q_r + 2'h1;
      {scl_r, sda_r} <= pat(kind_r, q_r + 2'h1, txw_r[8]);
    end
    else if (run_r)
      div_r <= div_r + 4'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_r  <= 1'b1;
      s2_r  <= 1'b1;
      rxw_r <= '0;
    end
    else
    begin
      s1_r <= bus.sda;
      s2_r <= s1_r;
      if (tick && q_r == 2'h2 && kind_r == SYM_BIT)
        rxw_r <= {rxw_r[7:0], s2_r};
    end
  end

  // ==========================================
  // Transfer sequencer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r     <= C_IDLE;
      op_r     <= OP_WRITE;
      dev_r    <= '0;
      addr_r   <= '0;
      cnt_r    <= '0;
      lau_r    <= 1'b0;
      nack     <= 1'b0;
      done     <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end
    else
    begin
      done     <= 1'b0;
      rd_valid <= 1'b0;
      if (go)
        lau_r <= 1'b1;
      if (cmd_valid && cmd_ready)
      begin
        st_r   <= C_START;
        op_r   <= eep_op_e'(cmd_op);
        dev_r  <= cmd_dev;
        addr_r <= cmd_addr;
        cnt_r  <= cmd_len;
        nack   <= 1'b0;
      end
      else if (sym_done)
      begin
        lau_r <= 1'b0;
        unique case (st_r)
          C_START: st_r <= op_r == OP_RECOVER ? C_REC :
                           op_r == OP_CREAD ? C_RDEV : C_DEV;
          C_REC:   st_r <= C_RSTA;
          C_RSTA:  st_r <= op_r == OP_RECOVER ? C_STOP : C_RDEV;
          C_DEV, C_AHI, C_RDEV, C_ALO, C_WDAT:
          begin
            nack <= rxw_r[0];
            if (rxw_r[0] || (st_r == C_WDAT && last))
              st_r <= C_STOP;
            else if (st_r == C_DEV)
              st_r <= C_AHI;
            else if (st_r == C_AHI)
              st_r <= C_ALO;
            else if (st_r == C_ALO)
              st_r <= op_r == OP_WRITE ? C_WDAT : C_RSTA;
            else if (st_r == C_RDEV)
              st_r <= C_RDAT;
            else
              cnt_r <= cnt_r - 7'h01;
          end
          C_RDAT:
          begin
            rd_valid <= 1'b1;
            rd_data  <= rxw_r[8:1];
            cnt_r    <= cnt_r - 7'h01;
            if (last)
              st_r <= C_STOP;
          end
          C_STOP:
          begin
            done <= 1'b1;
            st_r <= C_IDLE;
          end
          C_IDLE:  st_r <= C_IDLE;
        endcase
      end
    end
  end

  assign bus.scl_o   = 1'b0;
  assign bus.scl_oe  = !scl_r;
  assign bus.sda_c_o = 1'b0;
  assign bus.sda_c_oe = !sda_r;
endmodule

// ===== src/eep_regs.svh
`ifndef EEP_REGS_SVH
`define EEP_REGS_SVH
// ==========================================
// Protocol constants
`define EEP_PREAMBLE    4'hA
`define EEP_WORD_BITS   4'h8
`define EEP_LAST_BIT    4'h8
`define EEP_PAGE_BYTES  64
`define EEP_MEM_BYTES   32768
`define EEP_TWR_MS      5
`define EEP_CLK_KHZ     200000
// ==========================================
// Link clock: four quarters of four cycles, 80 ns
`define EEP_QTR_LAST    4'h3
`define EEP_FIFO_W      8
`define EEP_FIFO_D      16
// Both bus lines idle high; starting the synchroniser there avoids a false edge
`define EEP_SYNC_IDLE   6'h30
`endif

// ===== src/eep_pkg.sv
package eep_pkg;
  typedef enum logic [2:0] {
    T_IDLE = 3'h0,
    T_DEV  = 3'h1,
    T_AHI  = 3'h3,
    T_ALO  = 3'h2,
    T_WDAT = 3'h6,
    T_RDAT = 3'h5
  } eep_tst_e;
  typedef enum logic [3:0] {
    C_IDLE  = 4'h0,
    C_START = 4'h1,
    C_DEV   = 4'h3,
    C_AHI   = 4'h2,
    C_ALO   = 4'h6,
    C_WDAT  = 4'h7,
    C_STOP  = 4'h5,
    C_RSTA  = 4'hE,
    C_RDEV  = 4'hF,
    C_RDAT  = 4'hD,
    C_REC   = 4'h4
  } eep_cst_e;
  typedef enum logic [1:0] {
    OP_WRITE   = 2'h0,
    OP_RREAD   = 2'h1,
    OP_CREAD   = 2'h2,
    OP_RECOVER = 2'h3
  } eep_op_e;
  typedef enum logic [1:0] {
    SYM_BIT   = 2'h0,
    SYM_START = 2'h1,
    SYM_STOP  = 2'h2
  } eep_sym_e;
endpackage

// ===== src/eep_if.sv
`timescale 1ns/1ps
// ==========================================
// Open-drain two-wire bus, pulled up when nobody drives
interface eep_if;
  logic scl_o;
  logic scl_oe;
  logic sda_c_o;
  logic sda_c_oe;
  logic sda_t_o;
  logic sda_t_oe;
  logic scl;
  logic sda;
  assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((sda_c_oe && !sda_c_o) || (sda_t_oe && !sda_t_o)) ? 1'b0 : 1'b1;
  modport ctrl (output scl_o, scl_oe, sda_c_o, sda_c_oe, input scl, sda);
  modport target (output sda_t_o, sda_t_oe, input scl, sda);
endinterface

// ===== src/eep_target.sv
// Functional notes
// - SDA change with SCL high is start/stop
// - Start is SDA fall while SCL high
// - Stop ends read; return to idle
// - Eight-bit words, acknowledge on ninth clock
// - Idle at power-up and after stop
// - Controller recovers bus: start, nine clocks, start, stop
// - Select word opens with fixed preamble
// - Three select bits match strap inputs
// - Last select bit: one read, zero write
// - Acknowledge match; mismatch returns to idle
// - Write-protect high blocks all array writes
// - Byte write: select, two address, data, stop
// - Stop after data starts 5 ms program cycle
// - Page write takes up to 64 bytes
// - Write address wraps within 64-byte page
// - Select acknowledged only after program cycle
// - Address counter holds last address plus one
// - Current read returns byte at counter
// - Random read: dummy write, repeated start, read
// - Sample on SCL rise, drive on fall
// - 512 pages of 64 bytes, 15-bit address
// - Controller acknowledge continues sequential read
`timescale 1ns/1ps
`include "eep_regs.svh"
module eep_target
  import eep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `EEP_TWR_MS * `EEP_CLK_KHZ
)(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic write_protect,
  input  wire logic chip_select_strap_2,
  input  wire logic chip_select_strap_1,
  input  wire logic chip_select_strap_0,
  output logic      prog_busy,
  eep_if.target     bus
);
  // ==========================================
  // Pin synchronisers and bus events
  logic [5:0]  s1_r;
  logic [5:0]  s2_r;
  logic        scl_p_r;
  logic        sda_p_r;
  logic        scl_s;
  logic        sda_s;
  logic        wp_s;
  logic [2:0]  strap_s;
  logic        rise;
  logic        fall;
  logic        start_ev;
  logic        stop_ev;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_r    <= `EEP_SYNC_IDLE;
      s2_r    <= `EEP_SYNC_IDLE;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end
    else
    begin
      s1_r    <= {bus.scl, bus.sda, write_protect,
                  chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
      s2_r    <= s1_r;
      scl_p_r <= s2_r[5];
      sda_p_r <= s2_r[4];
    end
  end

  assign scl_s    = s2_r[5];
  assign sda_s    = s2_r[4];
  assign wp_s     = s2_r[3];
  assign strap_s  = s2_r[2:0];
  assign rise     = scl_s && !scl_p_r;
  assign fall     = !scl_s && scl_p_r;
  assign start_ev = scl_s && scl_p_r && sda_p_r && !sda_s;
  assign stop_ev  = scl_s && scl_p_r && !sda_p_r && sda_s;

  // ==========================================
  // Protocol state
  eep_tst_e    state_r;
  logic [3:0]  bit_r;
  logic        ackph_r;
  logic [7:0]  shreg_r;
  logic        oe_r;
  logic        mack_r;
  logic        rd_r;
  logic        wrote_r;
  logic        busy_r;
  logic [14:0] addr_r;
  logic [31:0] pcnt_r;
  logic [63:0] pval_r;
  logic [7:0]  mem [`EEP_MEM_BYTES];
  logic [7:0]  pbuf [`EEP_PAGE_BYTES];
  logic        live;
  logic        ack_enter;
  logic        ack_leave;
  logic        rd_load;
  logic        take_byte;
  logic        commit;
  logic        sel_match;

  // Bus ignored entirely while programming
  assign live      = !busy_r && !start_ev && !stop_ev && state_r != T_IDLE;
  assign ack_enter = live && fall && !ackph_r && bit_r == `EEP_LAST_BIT;
  assign ack_leave = live && fall && ackph_r;
  assign rd_load   = ack_leave && ((state_r == T_DEV && rd_r) ||
                                   (state_r == T_RDAT && !mack_r));
  assign take_byte = ack_enter && state_r == T_WDAT && !wp_s;
  assign commit    = !busy_r && stop_ev && state_r == T_WDAT && wrote_r;
  assign sel_match = shreg_r[7:4] == `EEP_PREAMBLE &&
                     shreg_r[3:1] == strap_s;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= T_IDLE;
      bit_r   <= '0;
      ackph_r <= 1'b0;
      shreg_r <= '0;
      oe_r    <= 1'b0;
      mack_r  <= 1'b0;
      rd_r    <= 1'b0;
      wrote_r <= 1'b0;
    end
    else if (busy_r)
    begin
      state_r <= T_IDLE;
      oe_r    <= 1'b0;
    end
    else if (start_ev)
    begin
      state_r <= T_DEV;
      bit_r   <= '0;
      ackph_r <= 1'b0;
      oe_r    <= 1'b0;
      wrote_r <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_r <= T_IDLE;
      ackph_r <= 1'b0;
      oe_r    <= 1'b0;
    end
    else if (state_r != T_IDLE)
    begin
      if (rise && ackph_r)
        mack_r <= sda_s;
      else if (rise)
      begin
        bit_r <= bit_r + 4'h1;
        if (state_r != T_RDAT)
          shreg_r <= {shreg_r[6:0], sda_s};
      end
      else if (ack_leave)
      begin
        ackph_r <= 1'b0;
        bit_r   <= '0;
        oe_r    <= 1'b0;
        if (rd_load)
        begin
          shreg_r <= mem[addr_r];
          oe_r    <= !mem[addr_r][7];
        end
        unique case (state_r)
          T_DEV:   state_r <= rd_r ? T_RDAT : T_AHI;
          T_AHI:   state_r <= T_ALO;
          T_ALO:   state_r <= T_WDAT;
          T_WDAT:  state_r <= T_WDAT;
          T_RDAT:  state_r <= mack_r ? T_IDLE : T_RDAT;
          T_IDLE:  state_r <= T_IDLE;
        endcase
      end
      else if (ack_enter)
      begin
        ackph_r <= 1'b1;
        unique case (state_r)
          T_DEV:
          begin
            rd_r    <= shreg_r[0];
            oe_r    <= sel_match;
            state_r <= sel_match ? T_DEV : T_IDLE;
          end
          T_AHI:   oe_r <= 1'b1;
          T_ALO:   oe_r <= 1'b1;
          T_WDAT:
          begin
            oe_r    <= !wp_s;
            wrote_r <= wrote_r || !wp_s;
          end
          T_RDAT:  oe_r <= 1'b0;
          T_IDLE:  oe_r <= 1'b0;
        endcase
      end
      else if (fall && state_r == T_RDAT)
      begin
        shreg_r <= {shreg_r[6:0], 1'b1};
        oe_r    <= !shreg_r[6];
      end
    end
  end

  // ==========================================
  // Address counter survives between operations
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      addr_r <= '0;
    else if (ack_enter && state_r == T_AHI)
      addr_r[14:8] <= shreg_r[6:0];
    else if (ack_enter && state_r == T_ALO)
      addr_r[7:0] <= shreg_r;
    else if (take_byte)
      addr_r[5:0] <= addr_r[5:0] + 6'h01;
    else if (rd_load)
      addr_r <= addr_r + 15'h0001;
  end

  // ==========================================
  // Page buffer; array is only touched by the timed cycle
  always_ff @(posedge clk)
  begin
    if (take_byte)
      pbuf[addr_r[5:0]] <= shreg_r;
  end

  // A one-byte-per-cycle copy keeps the array single-ported
  always_ff @(posedge clk)
  begin
    if (busy_r && pcnt_r < `EEP_PAGE_BYTES && pval_r[pcnt_r[5:0]])
      mem[{addr_r[14:6], pcnt_r[5:0]}] <= pbuf[pcnt_r[5:0]];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_r <= 1'b0;
      pcnt_r <= '0;
      pval_r <= '0;
    end
    else if (busy_r)
    begin
      pcnt_r <= pcnt_r + 32'h1;
      if (pcnt_r == PROG_CYCLES - 1)
      begin
        busy_r <= 1'b0;
        pval_r <= '0;
      end
    end
    else if (commit)
    begin
      busy_r <= 1'b1;
      pcnt_r <= '0;
    end
    else if (start_ev)
      pval_r <= '0;
    else if (take_byte)
      pval_r[addr_r[5:0]] <= 1'b1;
  end

  assign bus.sda_t_o  = 1'b0;
  assign bus.sda_t_oe = oe_r;
  assign prog_busy    = busy_r;
endmodule

// ===== testbench/eep_checker.sv
`timescale 1ns/1ps
// ==========================================
// Two-wire link checker, watches the resolved wires and the target side
module eep_checker #(
  parameter int unsigned PROG_CYCLES = 200
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_t_o,
  input wire logic sda_t_oe,
  input wire logic prog_busy
);
  logic [20:0] busy_cnt_r;
  logic [7:0]  stop_age_r;
  logic [5:0]  hi_cnt_r;
  logic        sda_q_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================
  // Helper counters
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      busy_cnt_r <= '0;
    else
      busy_cnt_r <= prog_busy ? busy_cnt_r + 1'b1 : '0;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      sda_q_r <= 1'b1;
    else
      sda_q_r <= sda;

  // Saturates so a long idle never wraps into a false recent stop
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      stop_age_r <= 8'hFF;
    else if (scl && sda && !sda_q_r)
      stop_age_r <= 8'h00;
    else if (stop_age_r != 8'hFF)
      stop_age_r <= stop_age_r + 1'b1;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      hi_cnt_r <= 6'h00;
    else if (!scl)
      hi_cnt_r <= 6'h00;
    else if (hi_cnt_r != 6'h3F)
      hi_cnt_r <= hi_cnt_r + 1'b1;

  // ==========================================
  // Assertions
  AST_TGT_MOVES_SCL_LOW: assert property (
    $changed(sda_t_oe) |-> !scl) else $error("target data moved with clock high");
  AST_TGT_PULLS_LOW: assert property (
    sda_t_oe |-> !sda_t_o && !sda) else $error("target drive is not a low pull");
  AST_TGT_HOLDS_HIGH: assert property (
    $rose(scl) && sda_t_oe |-> sda_t_oe [*8]) else $error("target data changed in high phase");
  AST_SCL_HIGH_PHASE: assert property (
    $rose(scl) |-> scl [*8]) else $error("clock high phase too short");
  AST_BUSY_QUIET: assert property (
    prog_busy |-> !sda_t_oe) else $error("target drove data while programming");
  AST_BUSY_AFTER_STOP: assert property (
    $rose(prog_busy) |-> stop_age_r < 8'h0C) else $error("program cycle without a stop");
  AST_BUSY_MAX: assert property (
    prog_busy |-> busy_cnt_r <= PROG_CYCLES) else $error("program cycle too long");
  AST_BUSY_MIN: assert property (
    $fell(prog_busy) |-> busy_cnt_r + 2 >= PROG_CYCLES) else $error("program cycle too short");
  AST_IDLE_RELEASED: assert property (
    hi_cnt_r > 6'h14 |-> !sda_t_oe) else $error("target holds data line while idle");
endmodule

// ===== testbench/serial_eeprom_two_wire_slave_test.sv
`timescale 1ns/1ps
// ==========================================
// Controller end against target end over the shared link
module serial_eeprom_two_wire_slave_test
  import eep_pkg::*;
;
  localparam int unsigned PROG = 200;
  logic        clk       = 1'b0;
  logic        rstn      = 1'b0;
  logic        wp        = 1'b0;
  logic [2:0]  strap     = 3'h3;
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_op    = 2'h0;
  logic [2:0]  cmd_dev   = 3'h0;
  logic [14:0] cmd_addr  = 15'h0000;
  logic [6:0]  cmd_len   = 7'h00;
  logic        wr_valid  = 1'b0;
  logic [7:0]  wr_data   = 8'h00;
  logic        cmd_ready;
  logic        wr_ready;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        done;
  logic        nack;
  logic        prog_busy;
  logic [7:0]  rq[$];
  int          mismatches  = 0;
  int          check_count = 0;

  eep_if bus_if ();

  always #2.5 clk = ~clk;

  eep_ctrl u_eep_ctrl (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .nack(nack), .bus(bus_if));
  eep_target #(.PROG_CYCLES(PROG)) u_eep_target (.clk(clk), .rstn(rstn), .write_protect(wp),
    .chip_select_strap_2(strap[2]), .chip_select_strap_1(strap[1]),
    .chip_select_strap_0(strap[0]), .prog_busy(prog_busy), .bus(bus_if));
  eep_checker #(.PROG_CYCLES(PROG)) u_eep_checker (.clk(clk), .rstn(rstn), .scl(bus_if.scl),
    .sda(bus_if.sda), .sda_t_o(bus_if.sda_t_o), .sda_t_oe(bus_if.sda_t_oe),
    .prog_busy(prog_busy));

  // ==========================================
  // Compare, drive and verdict tasks
  task check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task check_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Ready is combinational, so it is judged mid-cycle and taken at the next edge
  task push(input logic [7:0] b);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_data  <= b;
    @(negedge clk);
    while (wr_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    wr_valid <= 1'b0;
  endtask

  task run(input logic [1:0] op, input logic [2:0] dev, input logic [14:0] a, input int len);
    int n;
    rq.delete();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_dev   <= dev;
    cmd_addr  <= a;
    cmd_len   <= 7'(len);
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      n++;
    end
    while (done !== 1'b1 && n < 40000);
    check_bit("done", 1'b1, done);
  endtask

  task wait_idle;
    int n;
    n = 0;
    while (prog_busy !== 1'b0 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    check_bit("program end", 1'b0, prog_busy);
  endtask

  // ==========================================
  // Scenarios
  task test_write_read;
    push(8'h5A);
    push(8'hA5);
    run(OP_WRITE, 3'h3, 15'h1234, 2);
    check_bit("write nack", 1'b0, nack);
    check_bit("busy after stop", 1'b1, prog_busy);
    run(OP_CREAD, 3'h3, 15'h0000, 1);
    check_bit("poll while busy", 1'b1, nack);
    wait_idle();
    run(OP_RREAD, 3'h3, 15'h1234, 1);
    check_byte("random read", 8'h5A, rq[0]);
    check_bit("poll after cycle", 1'b0, nack);
    run(OP_CREAD, 3'h3, 15'h0000, 1);
    check_byte("current read", 8'hA5, rq[0]);
  endtask

  task test_page_wrap;
    for (int i = 0; i < 16; i++) push(8'hB0 + 8'(i));
    @(negedge clk);
    check_bit("fifo full", 1'b0, wr_ready);
    run(OP_WRITE, 3'h3, 15'h0438, 16);
    check_bit("page nack", 1'b0, nack);
    wait_idle();
    run(OP_RREAD, 3'h3, 15'h0400, 1);
    check_byte("page wrap", 8'hB8, rq[0]);
    run(OP_RREAD, 3'h3, 15'h043F, 1);
    check_byte("page end", 8'hB7, rq[0]);
  endtask

  task test_seq_wrap;
    push(8'hC1);
    run(OP_WRITE, 3'h3, 15'h7FFF, 1);
    wait_idle();
    push(8'hC2);
    run(OP_WRITE, 3'h3, 15'h0000, 1);
    wait_idle();
    run(OP_RREAD, 3'h3, 15'h7FFF, 2);
    check_byte("array top", 8'hC1, rq[0]);
    check_byte("read wrap", 8'hC2, rq[1]);
  endtask

  task test_protect;
    @(posedge clk);
    wp <= 1'b1;
    push(8'h00);
    run(OP_WRITE, 3'h3, 15'h1234, 1);
    check_bit("protected nack", 1'b1, nack);
    check_bit("protected busy", 1'b0, prog_busy);
    @(posedge clk);
    wp <= 1'b0;
    run(OP_RREAD, 3'h3, 15'h1234, 1);
    check_byte("protected data", 8'h5A, rq[0]);
  endtask

  task test_straps;
    for (int v = 0; v < 8; v++)
    begin
      @(posedge clk);
      strap <= 3'(v);
      repeat (4) @(posedge clk);
      run(OP_CREAD, 3'(v) ^ 3'h1, 15'h0000, 1);
      check_bit("strap mismatch", 1'b1, nack);
      run(OP_CREAD, 3'(v), 15'h0000, 1);
      check_bit("strap match", 1'b0, nack);
    end
    @(posedge clk);
    strap <= 3'h3;
    repeat (4) @(posedge clk);
  endtask

  task test_recover;
    run(OP_RECOVER, 3'h3, 15'h0000, 1);
    run(OP_RREAD, 3'h3, 15'h1234, 1);
    check_byte("after recovery", 8'h5A, rq[0]);
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    test_write_read();
    test_page_wrap();
    test_seq_wrap();
    test_protect();
    test_straps();
    test_recover();
    give_verdict();
  end

  // Whole run is near 16k cycles; this allows over three times that
  initial
  begin
    #300000;
    mismatches++;
    give_verdict();
  end
endmodule
